/* File: core/cms_pkg.sv */
package cms_pkg;
    // Register location on the special-function register bus
    localparam logic [7:0] SFR_PAGE_CMP = 8'h00;
    localparam logic [7:0] ADDR_MODE1 = 8'h9C;
    localparam logic [7:0] ADDR_MUX0 = 8'h9F;
    // Field positions of the comparator-1 mode register
    localparam int MODE1_RSVD_BIT = 7;
    localparam int MODE1_RISE_EN_BIT = 5;
    localparam int MODE1_FALL_EN_BIT = 4;
    localparam int MODE1_SPEED_LSB = 0;
    localparam int MODE1_SPEED_W = 2;
    // Field positions of the comparator-0 input select register
    localparam int MUX0_NEG_LSB = 4;
    localparam int MUX0_POS_LSB = 0;
    localparam int MUX0_SEL_W = 4;
    // Reset values
    localparam logic [7:0] MODE1_RESET = 8'h82;
    localparam logic [7:0] MUX0_RESET = 8'hFF;
    // Special selector codes
    localparam logic [3:0] SEL_NEG_RESERVED = 4'hB;
    localparam logic [3:0] SEL_TOUCH_REF = 4'hC;
    localparam logic [3:0] SEL_HALF_SUPPLY = 4'hD;
    // Timer capture source codes
    localparam logic CAP_SRC_CMP0 = 1'b0;
    localparam logic CAP_SRC_CMP1 = 1'b1;
endpackage

/* File: core/cms_comparator_regs.sv */
`timescale 1ns/1ps
module cms_comparator_regs
(
    input wire logic sys_clk_i, // 40 MHz core clock
    input wire logic resetn_i, // Asynchronous reset, active low
    // Special-function register bus
    input wire logic [7:0] sfr_page_i, // Current register page
    input wire logic [7:0] sfr_addr_i, // Register address
    input wire logic sfr_wr_i, // Write strobe, one cycle
    input wire logic [7:0] sfr_wdata_i, // Write data
    input wire logic sfr_rd_i, // Read strobe, one cycle
    output logic [7:0] sfr_rdata_o, // Read data, one cycle after strobe
    output logic sfr_rvalid_o, // Read data valid, one-cycle pulse
    // Analog comparator side
    input wire logic cmp0_out_i, // Raw comparator-0 output
    input wire logic cmp1_out_i, // Raw comparator-1 output
    input wire logic cmp1_half_sel_i, // Comparator-1 mux picks half supply
    input wire logic cmp1_rise_clr_i, // Software clear of rise flag
    input wire logic cmp1_fall_clr_i, // Software clear of fall flag
    output logic [1:0] cmp1_speed_power_mode_o, // Response/power mode
    output logic [3:0] cmp0_neg_select_o, // Negative input channel
    output logic [3:0] cmp0_pos_select_o, // Positive input channel
    output logic cmp0_neg_open_o, // Negative code is reserved
    output logic cmp0_touch_ref_neg_o, // Touch reference on negative
    output logic cmp0_touch_ref_pos_o, // Touch reference on positive
    output logic half_div_en_o, // Half-supply divider enable
    output logic cmp1_rise_flag_o, // Sticky rising-edge flag
    output logic cmp1_fall_flag_o, // Sticky falling-edge flag
    output logic cmp1_irq_o, // Comparator-1 interrupt request
    // Timer capture routing
    input wire logic second_timer_src_i, // 0 comparator-0, 1 comparator-1
    input wire logic third_timer_src_i, // 0 comparator-0, 1 comparator-1
    output logic second_timer_cap_o, // Capture input of second timer
    output logic third_timer_cap_o // Capture input of third timer
);

    // ****************************************************
    // Register storage
    // ****************************************************
    logic rise_en_reg;
    logic rise_en_next;
    logic fall_en_reg;
    logic fall_en_next;
    logic [1:0] speed_reg;
    logic [1:0] speed_next;
    logic [7:0] mux0_reg;
    logic [7:0] mux0_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic hit_mode1;
    logic hit_mux0;
    logic [7:0] mode1_view;

    // Decode only page 0; other pages leave both registers alone
    always_comb
    begin
        hit_mode1 = (sfr_page_i == cms_pkg::SFR_PAGE_CMP)
            && (sfr_addr_i == cms_pkg::ADDR_MODE1);
        hit_mux0 = (sfr_page_i == cms_pkg::SFR_PAGE_CMP)
            && (sfr_addr_i == cms_pkg::ADDR_MUX0);
    end

    // Readback of the mode register; fixed bits are built, not stored
    always_comb
    begin
        mode1_view = 8'h00;
        mode1_view[cms_pkg::MODE1_RSVD_BIT] = 1'b1;
        mode1_view[cms_pkg::MODE1_RISE_EN_BIT] = rise_en_reg;
        mode1_view[cms_pkg::MODE1_FALL_EN_BIT] = fall_en_reg;
        mode1_view[cms_pkg::MODE1_SPEED_LSB +: cms_pkg::MODE1_SPEED_W] =
            speed_reg;
    end

    // Next state of the software registers and read path
    always_comb
    begin
        rise_en_next = rise_en_reg;
        fall_en_next = fall_en_reg;
        speed_next = speed_reg;
        mux0_next = mux0_reg;
        rdata_next = 8'h00;
        rvalid_next = sfr_rd_i;
        // Written bits 7, 6, 3, 2 are dropped on purpose
        if (sfr_wr_i && hit_mode1)
        begin
            rise_en_next = sfr_wdata_i[cms_pkg::MODE1_RISE_EN_BIT];
            fall_en_next = sfr_wdata_i[cms_pkg::MODE1_FALL_EN_BIT];
            speed_next = sfr_wdata_i[cms_pkg::MODE1_SPEED_LSB +:
                cms_pkg::MODE1_SPEED_W];
        end
        if (sfr_wr_i && hit_mux0)
        begin
            mux0_next = sfr_wdata_i;
        end
        // Unmapped addresses read as zero
        if (sfr_rd_i && hit_mode1)
        begin
            rdata_next = mode1_view;
        end
        else if (sfr_rd_i && hit_mux0)
        begin
            rdata_next = mux0_reg;
        end
    end

    // Register the software state
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rise_en_reg <= cms_pkg::MODE1_RESET[cms_pkg::MODE1_RISE_EN_BIT];
            fall_en_reg <= cms_pkg::MODE1_RESET[cms_pkg::MODE1_FALL_EN_BIT];
            speed_reg <= cms_pkg::MODE1_RESET[1:0];
            mux0_reg <= cms_pkg::MUX0_RESET;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rise_en_reg <= rise_en_next;
            fall_en_reg <= fall_en_next;
            speed_reg <= speed_next;
            mux0_reg <= mux0_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ****************************************************
    // Comparator output synchronisers and edge flags
    // ****************************************************
    logic [1:0] sync0_reg;
    logic [1:0] sync0_next;
    logic [1:0] sync1_reg;
    logic [1:0] sync1_next;
    logic last1_reg;
    logic last1_next;
    logic rise_flag_reg;
    logic rise_flag_next;
    logic fall_flag_reg;
    logic fall_flag_next;
    logic irq_reg;
    logic irq_next;

    // Analog outputs are asynchronous; only stage 2 is examined
    always_comb
    begin
        sync0_next = {sync0_reg[0], cmp0_out_i};
        sync1_next = {sync1_reg[0], cmp1_out_i};
        last1_next = sync1_reg[1];
        rise_flag_next = rise_flag_reg;
        fall_flag_next = fall_flag_reg;
        // A clear in the same cycle as an edge loses to the edge
        if (cmp1_rise_clr_i)
        begin
            rise_flag_next = 1'b0;
        end
        if (cmp1_fall_clr_i)
        begin
            fall_flag_next = 1'b0;
        end
        if (sync1_reg[1] && !last1_reg)
        begin
            rise_flag_next = 1'b1;
        end
        if (!sync1_reg[1] && last1_reg)
        begin
            fall_flag_next = 1'b1;
        end
        // Built from next values so the request tracks its flop outputs
        irq_next = (rise_flag_next && rise_en_next)
            || (fall_flag_next && fall_en_next);
    end

    // Register synchronisers, flags and request
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync0_reg <= 2'h0;
            sync1_reg <= 2'h0;
            last1_reg <= 1'b0;
            rise_flag_reg <= 1'b0;
            fall_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            sync0_reg <= sync0_next;
            sync1_reg <= sync1_next;
            last1_reg <= last1_next;
            rise_flag_reg <= rise_flag_next;
            fall_flag_reg <= fall_flag_next;
            irq_reg <= irq_next;
        end
    end

    // ****************************************************
    // Analog steering and timer capture routing
    // ****************************************************
    logic [3:0] neg_sel;
    logic [3:0] pos_sel;
    logic neg_open_reg;
    logic neg_open_next;
    logic touch_neg_reg;
    logic touch_neg_next;
    logic touch_pos_reg;
    logic touch_pos_next;
    logic half_en_reg;
    logic half_en_next;
    logic cap2_reg;
    logic cap2_next;
    logic cap3_reg;
    logic cap3_next;

    // Steering follows the new select value so outputs change with it
    always_comb
    begin
        neg_sel = mux0_next[cms_pkg::MUX0_NEG_LSB +: cms_pkg::MUX0_SEL_W];
        pos_sel = mux0_next[cms_pkg::MUX0_POS_LSB +: cms_pkg::MUX0_SEL_W];
        neg_open_next = (neg_sel == cms_pkg::SEL_NEG_RESERVED);
        touch_neg_next = (neg_sel == cms_pkg::SEL_TOUCH_REF);
        touch_pos_next = (pos_sel == cms_pkg::SEL_TOUCH_REF);
        // Divider burns current, so it runs only while selected
        half_en_next = (neg_sel == cms_pkg::SEL_HALF_SUPPLY)
            || (pos_sel == cms_pkg::SEL_HALF_SUPPLY)
            || cmp1_half_sel_i;
        cap2_next = (second_timer_src_i == cms_pkg::CAP_SRC_CMP1)
            ? sync1_reg[1] : sync0_reg[1];
        cap3_next = (third_timer_src_i == cms_pkg::CAP_SRC_CMP1)
            ? sync1_reg[1] : sync0_reg[1];
    end

    // Register the steering outputs; FF code sets no steering output, though cmp1_half_sel_i can still raise the divider
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            neg_open_reg <= 1'b0;
            touch_neg_reg <= 1'b0;
            touch_pos_reg <= 1'b0;
            half_en_reg <= 1'b0;
            cap2_reg <= 1'b0;
            cap3_reg <= 1'b0;
        end
        else
        begin
            neg_open_reg <= neg_open_next;
            touch_neg_reg <= touch_neg_next;
            touch_pos_reg <= touch_pos_next;
            half_en_reg <= half_en_next;
            cap2_reg <= cap2_next;
            cap3_reg <= cap3_next;
        end
    end

    // Output connections, all from flops
    assign sfr_rdata_o = rdata_reg;
    assign sfr_rvalid_o = rvalid_reg;
    assign cmp1_speed_power_mode_o = speed_reg;
    assign cmp0_neg_select_o =
        mux0_reg[cms_pkg::MUX0_NEG_LSB +: cms_pkg::MUX0_SEL_W];
    assign cmp0_pos_select_o =
        mux0_reg[cms_pkg::MUX0_POS_LSB +: cms_pkg::MUX0_SEL_W];
    assign cmp0_neg_open_o = neg_open_reg;
    assign cmp0_touch_ref_neg_o = touch_neg_reg;
    assign cmp0_touch_ref_pos_o = touch_pos_reg;
    assign half_div_en_o = half_en_reg;
    assign cmp1_rise_flag_o = rise_flag_reg;
    assign cmp1_fall_flag_o = fall_flag_reg;
    assign cmp1_irq_o = irq_reg;
    assign second_timer_cap_o = cap2_reg;
    assign third_timer_cap_o = cap3_reg;

endmodule

/* File: bench/cms_regs_chk.sv */
`timescale 1ns/1ps
module cms_regs_chk
(
    input wire logic sys_clk_i, // Clock
    input wire logic resetn_i, // Reset
    input wire logic [7:0] sfr_page_i, // Page
    input wire logic [7:0] sfr_addr_i, // Address
    input wire logic sfr_wr_i, // Write
    input wire logic [7:0] sfr_wdata_i, // Data
    input wire logic sfr_rd_i, // Read
    input wire logic sfr_rvalid_o, // Valid
    input wire logic [1:0] cmp1_speed_power_mode_o, // Mode
    input wire logic [3:0] cmp0_neg_select_o, // Negative
    input wire logic [3:0] cmp0_pos_select_o, // Positive
    input wire logic cmp0_neg_open_o, // Reserved
    input wire logic cmp0_touch_ref_neg_o, // Touch neg
    input wire logic cmp0_touch_ref_pos_o, // Touch pos
    input wire logic half_div_en_o, // Divider
    input wire logic cmp1_half_sel_i, // Divider ask
    input wire logic cmp0_out_i, // Pin 0
    input wire logic cmp1_out_i, // Pin 1
    input wire logic cmp1_rise_clr_i, // Clear
    input wire logic cmp1_rise_flag_o, // Rise
    input wire logic cmp1_fall_flag_o, // Fall
    input wire logic cmp1_irq_o, // Request
    input wire logic second_timer_src_i, // Source
    input wire logic second_timer_cap_o // Capture
);
    // ****
    // Write decode and properties
    // ****
    logic hit_mode;
    logic hit_mux;
    logic [3:0] ng;
    logic [3:0] ps;
    // Only page 0 writes may reach the two registers
    assign hit_mode = sfr_wr_i && sfr_page_i == 8'h00 && sfr_addr_i == 8'h9C;
    assign hit_mux = sfr_wr_i && sfr_page_i == 8'h00 && sfr_addr_i == 8'h9F;
    assign ng = cmp0_neg_select_o;
    assign ps = cmp0_pos_select_o;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    a_read_answer: assert property (sfr_rd_i |=> sfr_rvalid_o)
        else $error("read not answered");
    a_mode_write: assert property (hit_mode |=>
        cmp1_speed_power_mode_o == $past(sfr_wdata_i[1:0]))
        else $error("mode field not written");
    a_mode_hold: assert property (!hit_mode |=>
        $stable(cmp1_speed_power_mode_o)) else $error("mode changed");
    a_mux_write: assert property (hit_mux |=>
        {ng, ps} == $past(sfr_wdata_i)) else $error("select not written");
    a_touch_map: assert property ({cmp0_touch_ref_neg_o,
        cmp0_touch_ref_pos_o, cmp0_neg_open_o} ==
        {ng == 4'hC, ps == 4'hC, ng == 4'hB}) else $error("steering wrong");
    a_half_div: assert property (half_div_en_o == (ng == 4'hD ||
        ps == 4'hD || $past(cmp1_half_sel_i))) else $error("divider wrong");
    a_irq_cause: assert property (cmp1_irq_o |->
        cmp1_rise_flag_o || cmp1_fall_flag_o) else $error("stray request");
    a_rise_sticky: assert property (cmp1_rise_flag_o &&
        !cmp1_rise_clr_i |=> cmp1_rise_flag_o) else $error("flag lost");
    a_rise_set: assert property ($rose(cmp1_out_i) ##1
        cmp1_out_i[*2] |=> ##[0:1] cmp1_rise_flag_o) else $error("no flag");
    a_cap_route: assert property (second_timer_cap_o ==
        ($past(second_timer_src_i) ? $past(cmp1_out_i, 3) :
        $past(cmp0_out_i, 3))) else $error("capture route wrong");
    cover property (hit_mode);
    cover property (cmp1_irq_o);
    cover property (half_div_en_o);
endmodule
bind cms_comparator_regs cms_regs_chk u_chk
(
    .sys_clk_i, .resetn_i, .sfr_page_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .sfr_rd_i, .sfr_rvalid_o, .cmp1_speed_power_mode_o,
    .cmp0_neg_select_o, .cmp0_pos_select_o, .cmp0_neg_open_o,
    .cmp0_touch_ref_neg_o, .cmp0_touch_ref_pos_o, .half_div_en_o,
    .cmp1_half_sel_i, .cmp0_out_i, .cmp1_out_i, .cmp1_rise_clr_i,
    .cmp1_rise_flag_o, .cmp1_fall_flag_o, .cmp1_irq_o,
    .second_timer_src_i, .second_timer_cap_o
);

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] sfr_page_i = 8'h00;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic sfr_rd_i = 1'b0;
    logic [7:0] sfr_rdata_o;
    logic sfr_rvalid_o;
    logic cmp0_out_i = 1'b0;
    logic cmp1_out_i = 1'b0;
    logic cmp1_half_sel_i = 1'b0;
    logic cmp1_rise_clr_i = 1'b0;
    logic cmp1_fall_clr_i = 1'b0;
    logic [1:0] cmp1_speed_power_mode_o;
    logic [3:0] cmp0_neg_select_o;
    logic [3:0] cmp0_pos_select_o;
    logic cmp0_neg_open_o;
    logic cmp0_touch_ref_neg_o;
    logic cmp0_touch_ref_pos_o;
    logic half_div_en_o;
    logic cmp1_rise_flag_o;
    logic cmp1_fall_flag_o;
    logic cmp1_irq_o;
    logic second_timer_src_i = 1'b0;
    logic third_timer_src_i = 1'b0;
    logic second_timer_cap_o;
    logic third_timer_cap_o;
    integer failures = 0;
    integer n_tests = 0;
    integer seed = 32'hD33D;
    logic [7:0] exp_q[$];
    logic [7:0] d;
    cms_comparator_regs dut
    (
        .sys_clk_i, .resetn_i, .sfr_page_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .sfr_rvalid_o, .cmp0_out_i,
        .cmp1_out_i, .cmp1_half_sel_i, .cmp1_rise_clr_i, .cmp1_fall_clr_i,
        .cmp1_speed_power_mode_o, .cmp0_neg_select_o, .cmp0_pos_select_o,
        .cmp0_neg_open_o, .cmp0_touch_ref_neg_o, .cmp0_touch_ref_pos_o,
        .half_div_en_o, .cmp1_rise_flag_o, .cmp1_fall_flag_o, .cmp1_irq_o,
        .second_timer_src_i, .third_timer_src_i, .second_timer_cap_o,
        .third_timer_cap_o
    );
    // ****
    // Clock, tasks and read monitor
    // ****
    initial
    begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle; strobes stay up when calls follow back to back
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] v, input logic [7:0] e);
        @(negedge sys_clk_i);
        sfr_wr_i = w;
        sfr_rd_i = r;
        sfr_addr_i = a;
        sfr_wdata_i = v;
        if (r)
            exp_q.push_back(e);
    endtask
    // Flag pins pack as rise, fall, request
    task automatic flags(input logic [2:0] e);
        check({5'h00, cmp1_rise_flag_o, cmp1_fall_flag_o, cmp1_irq_o},
            {5'h00, e});
    endtask
    task automatic give_verdict();
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Sampled at the falling edge, well clear of the register updates
    always @(negedge sys_clk_i)
    begin
        if (sfr_rvalid_o === 1'b1)
            check(sfr_rdata_o, exp_q.pop_front());
    end
    initial
    begin
        repeat (2000) @(posedge sys_clk_i);
        failures = failures + 1;
        give_verdict();
    end
    // ****
    // Main sequence
    // ****
    initial
    begin
        repeat (4) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        check({6'h00, cmp1_speed_power_mode_o}, 8'h02);
        acc(0, 1, 8'h9C, 8'h00, 8'h82);
        acc(0, 1, 8'h9F, 8'h00, 8'hFF);
        // Random writes, each read back in the very next cycle
        for (int i = 0; i < 8; i++)
        begin
            d = $random(seed);
            d[1:0] = i[1:0];
            acc(1, 0, 8'h9C, d, 8'h00);
            acc(0, 1, 8'h9C, 8'h00, {2'b10, d[5:4], 2'b00, d[1:0]});
            d = $random(seed);
            acc(1, 0, 8'h9F, d, 8'h00);
            acc(0, 1, 8'h9F, 8'h00, d);
        end
        // Special selector codes on both fields
        for (int i = 10; i < 16; i++)
        begin
            acc(1, 0, 8'h9F, {i[3:0], i[3:0]}, 8'h00);
            acc(0, 0, 8'h00, 8'h00, 8'h00);
            check({4'h0, cmp0_neg_open_o, cmp0_touch_ref_neg_o,
                cmp0_touch_ref_pos_o, half_div_en_o},
                {4'h0, i == 11, i == 12, i == 12, i == 13});
            check({cmp0_neg_select_o, cmp0_pos_select_o},
                {i[3:0], i[3:0]});
        end
        // Wrong page and unmapped address leave the mode register alone
        // Page moves only in an idle cycle, never under a live strobe
        acc(1, 0, 8'h9C, 8'h81, 8'h00);
        acc(0, 0, 8'h00, 8'h00, 8'h00);
        sfr_page_i = 8'h01;
        acc(1, 0, 8'h9C, 8'hFF, 8'h00);
        acc(0, 1, 8'h9C, 8'h00, 8'h00);
        acc(0, 0, 8'h00, 8'h00, 8'h00);
        sfr_page_i = 8'h00;
        acc(1, 0, 8'h9D, 8'hB3, 8'h00);
        acc(0, 1, 8'h9D, 8'h00, 8'h00);
        acc(0, 1, 8'h9C, 8'h00, 8'h81);
        // Edge flags against the enables
        acc(1, 0, 8'h9C, 8'hA0, 8'h00);
        acc(0, 0, 8'h00, 8'h00, 8'h00);
        cmp1_out_i = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        flags(3'b101);
        cmp1_out_i = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        flags(3'b111);
        acc(1, 0, 8'h9C, 8'h80, 8'h00);
        acc(0, 0, 8'h00, 8'h00, 8'h00);
        flags(3'b110);
        acc(1, 0, 8'h9C, 8'h90, 8'h00);
        acc(0, 0, 8'h00, 8'h00, 8'h00);
        flags(3'b111);
        {cmp1_rise_clr_i, cmp1_fall_clr_i} = 2'b11;
        @(negedge sys_clk_i);
        {cmp1_rise_clr_i, cmp1_fall_clr_i} = 2'b00;
        flags(3'b000);
        // Timer capture routing with random sources and pins
        for (int i = 0; i < 8; i++)
        begin
            d = $random(seed);
            {second_timer_src_i, third_timer_src_i} = d[3:2];
            // Raw comparator outputs driven directly from the random bits
            {cmp0_out_i, cmp1_out_i} = d[1:0];
            repeat (4) @(negedge sys_clk_i);
            check({second_timer_cap_o, third_timer_cap_o},
                {d[3] ? d[0] : d[1], d[2] ? d[0] : d[1]});
        end
        // Divider request from the other comparator
        cmp1_half_sel_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check({7'h00, half_div_en_o}, 8'h01);
        cmp1_half_sel_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        check({7'h00, half_div_en_o}, 8'h00);
        give_verdict();
    end
endmodule
